// ==== shared/asp_pkg.sv ====
package asp_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h99;

  // ==========================================================
  // Control register fields
  localparam int CTRL_FMT_BIT  = 7;
  localparam int CTRL_ONE_BIT  = 6;
  localparam int CTRL_MCE_BIT  = 5;
  localparam int CTRL_REN_BIT  = 4;
  localparam int CTRL_TB8_BIT  = 3;
  localparam int CTRL_RB8_BIT  = 2;
  localparam int CTRL_TI_BIT   = 1;
  localparam int CTRL_RI_BIT   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ==========================================================
  // Timing
  localparam logic [8:0] TMR_MODULUS = 9'h100;
  localparam logic [7:0] TMR_TOP     = 8'hFF;
  localparam logic [2:0] DATA_LAST   = 3'h7;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ASP_TX_IDLE,
    ASP_TX_WAIT,
    ASP_TX_START,
    ASP_TX_DATA,
    ASP_TX_NINTH,
    ASP_TX_STOP
  } asp_tx_state_t;

  typedef enum logic [2:0] {
    ASP_RX_IDLE,
    ASP_RX_START,
    ASP_RX_DATA,
    ASP_RX_NINTH,
    ASP_RX_STOP
  } asp_rx_state_t;

endpackage

// ==== sim/asp_assertions.sv ====
`timescale 1ns/1ps
module asp_assertions (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       tx_buf_ready,
  input wire logic       timer_run,
  input wire logic       timer_src_ext,
  input wire logic [7:0] bitrate_reload_value,
  input wire logic       irq_enable,
  input wire logic       serial_irq,
  input wire logic       serial_out_pin
);
  // ==========================================================
  // Helper: a data write has been seen since reset
  logic sent_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      sent_q <= 1'b0;
    end else if (sfr_wr && sfr_addr == asp_pkg::ADDR_DATA) begin
      sent_q <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // Properties
  reset_values_a: assert property ($fell(srst) |-> serial_out_pin && !serial_irq
      && sfr_rdata == 8'h00 && tx_buf_ready)
    else $error("outputs not at reset values after reset");
  irq_gate_a: assert property (!irq_enable |-> !serial_irq)
    else $error("interrupt raised while disabled");
  irq_hold_a: assert property (serial_irq && !sfr_wr |=> serial_irq || !irq_enable)
    else $error("flag cleared without a software write");
  unused_bit_a: assert property (sfr_rd && sfr_addr == asp_pkg::ADDR_CTRL |=> sfr_rdata[6])
    else $error("control bit 6 did not read as one");
  unmapped_rd_a: assert property (sfr_rd && sfr_addr != asp_pkg::ADDR_CTRL
      && sfr_addr != asp_pkg::ADDR_DATA |=> sfr_rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  start_width_a: assert property ($fell(serial_out_pin) && timer_run && !timer_src_ext
      && bitrate_reload_value == 8'hFE |-> !serial_out_pin [*4])
    else $error("start bit shorter than one bit time");
  tx_cause_a: assert property ($fell(serial_out_pin) |-> sent_q)
    else $error("transmit began without a data write");
  full_cause_a: assert property ($fell(tx_buf_ready) |-> $past(sfr_wr)
      && $past(sfr_addr) == asp_pkg::ADDR_DATA)
    else $error("buffer filled without a data write");
endmodule

bind asp_top asp_assertions chk_u (
  .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .tx_buf_ready(tx_buf_ready), .timer_run(timer_run),
  .timer_src_ext(timer_src_ext), .bitrate_reload_value(bitrate_reload_value),
  .irq_enable(irq_enable), .serial_irq(serial_irq), .serial_out_pin(serial_out_pin)
);

// ==== sim/asp_remote.sv ====
`timescale 1ns/1ps
module asp_remote (
  input wire logic clk,
  input wire logic line_in,
  output logic     line_out
);
  int         bit_clk = 4;
  logic       nine    = 1'b0;
  logic [9:0] got_q[$];

  initial line_out = 1'b1;

  // Frame bits: start, data LSB first, optional ninth, stop; line rests high
  task automatic send(input logic [7:0] d, input logic b9, input logic stop);
    logic [10:0] f;
    f = {stop, b9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || nine) begin
        line_out = f[i];
        repeat (bit_clk) @(negedge clk);
      end
    end
    // A high stop bit already rests the line; a second write here would
    // collide with the start bit of a back-to-back call
    if (!stop) begin
      line_out = 1'b1;
    end
  endtask

  // Samples mid-cell; stops at the stop bit so a back-to-back start is not missed
  always begin
    logic [9:0] w;
    w = 10'h3FF;
    @(negedge line_in);
    repeat (bit_clk / 2) @(posedge clk);
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      repeat (bit_clk) @(posedge clk);
      w[i] = line_in;
    end
    got_q.push_back(w);
  end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] d;
    logic       b9;
    logic       stop;
    logic [7:0] xd;
    logic [7:0] xc;
  } asp_row_t;

  logic       clk          = 1'b0;
  logic       srst         = 1'b1;
  logic [7:0] sfr_addr     = 8'h00;
  logic       sfr_wr       = 1'b0;
  logic       sfr_rd       = 1'b0;
  logic [7:0] sfr_wdata    = 8'h00;
  logic       ext_sel      = 1'b0;
  logic       ext_clk      = 1'b0;
  logic       irq_en       = 1'b0;
  logic [7:0] rld          = 8'hFE;
  logic       tmr_run      = 1'b1;
  logic [7:0] sfr_rdata;
  logic       tx_buf_ready;
  logic       serial_irq;
  logic       rx_line;
  logic       tx_line;
  int         num_errors   = 0;
  int         checked      = 0;
  asp_row_t   rows [7]     = '{
    '{8'h10, 8'hA5, 1'b0, 1'b1, 8'hA5, 8'h55}, '{8'h30, 8'h3C, 1'b0, 1'b0, 8'hA5, 8'h70},
    '{8'h10, 8'h3C, 1'b0, 1'b0, 8'h3C, 8'h51}, '{8'hB0, 8'h66, 1'b0, 1'b1, 8'h3C, 8'hF0},
    '{8'hB0, 8'h81, 1'b1, 1'b1, 8'h81, 8'hF5}, '{8'h90, 8'h5A, 1'b0, 1'b0, 8'h5A, 8'hD1},
    '{8'h00, 8'h77, 1'b0, 1'b1, 8'h5A, 8'h40}};

  always #50 clk = ~clk;
  // External oscillator well below clk/4 so the synchroniser sees each edge
  always #300 ext_clk = ~ext_clk;

  asp_top dut_u (
    .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tx_buf_ready(tx_buf_ready),
    .timer_run(tmr_run), .timer_src_ext(ext_sel), .ext_osc_clk(ext_clk),
    .bitrate_reload_value(rld), .irq_enable(irq_en), .serial_irq(serial_irq),
    .serial_in_pin(rx_line), .serial_out_pin(tx_line)
  );
  asp_remote rem_u (.clk(clk), .line_in(tx_line), .line_out(rx_line));

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string nm);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(nm, sfr_rdata, exp);
    @(negedge clk);
  endtask
  task automatic wait_rx(input int n);
    for (int k = 0; k < 3000 && rem_u.got_q.size() < n; k++) @(negedge clk);
  endtask
  task automatic end_sim;
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    srst = 1'b0;
    chk("tx_idle", tx_line, 10'h001);
    rc(asp_pkg::ADDR_CTRL, asp_pkg::CTRL_RESET, "ctrl_reset");
    rc(asp_pkg::ADDR_DATA, asp_pkg::DATA_RESET, "data_reset");
    rc(8'h9A, 8'h00, "unmapped");
    foreach (rows[i]) begin
      wr(asp_pkg::ADDR_CTRL, rows[i].ctrl);
      rem_u.nine = rows[i].ctrl[7];
      rem_u.send(rows[i].d, rows[i].b9, rows[i].stop);
      repeat (8) @(negedge clk);
      rc(asp_pkg::ADDR_DATA, rows[i].xd, "rx_data");
      rc(asp_pkg::ADDR_CTRL, rows[i].xc, "rx_ctrl");
    end
    wr(asp_pkg::ADDR_CTRL, 8'h10);
    rem_u.nine = 1'b0;
    rem_u.send(8'h11, 1'b0, 1'b1);
    rem_u.send(8'h22, 1'b0, 1'b1);
    repeat (8) @(negedge clk);
    rc(asp_pkg::ADDR_DATA, 8'h11, "overrun");
    irq_en = 1'b1;
    wr(asp_pkg::ADDR_CTRL, 8'h88);
    rem_u.nine = 1'b1;
    wr(asp_pkg::ADDR_DATA, 8'hC3);
    wait_rx(1);
    chk("tx_nine", rem_u.got_q.pop_front(), 10'h3C3);
    rc(asp_pkg::ADDR_CTRL, 8'hCA, "tx_flag");
    chk("irq_set", serial_irq, 10'h001);
    rc(asp_pkg::ADDR_CTRL, 8'hCA, "flag_kept");
    rc(asp_pkg::ADDR_DATA, 8'h11, "no_tx_read");
    wr(asp_pkg::ADDR_CTRL, 8'h00);
    chk("irq_clr", serial_irq, 10'h000);
    // Four writes back to back: one goes out, two wait, the last is refused
    rem_u.nine = 1'b0;
    sfr_addr = asp_pkg::ADDR_DATA;
    sfr_wr = 1'b1;
    for (int i = 0; i < 4; i++) begin
      sfr_wdata = 8'h10 + 8'(i);
      @(negedge clk);
    end
    sfr_wr = 1'b0;
    chk("buf_full", tx_buf_ready, 10'h000);
    wait_rx(3);
    repeat (200) @(negedge clk);
    chk("tx_count", 10'(rem_u.got_q.size()), 10'h003);
    chk("tx_first", rem_u.got_q[0], 10'h310);
    chk("tx_second", rem_u.got_q[1], 10'h311);
    chk("tx_third", rem_u.got_q[2], 10'h312);
    // A stopped timer holds the frame back; reload 0xFC doubles the bit time
    tmr_run = 1'b0;
    rld = 8'hFC;
    rem_u.bit_clk = 8;
    wr(asp_pkg::ADDR_DATA, 8'hA6);
    repeat (40) @(negedge clk);
    chk("tx_held", tx_line, 10'h001);
    tmr_run = 1'b1;
    wait_rx(4);
    chk("tx_slow", rem_u.got_q[3], 10'h3A6);
    rld = 8'hFE;
    ext_sel = 1'b1;
    rem_u.bit_clk = 24;
    wr(asp_pkg::ADDR_CTRL, 8'h10);
    rem_u.send(8'h96, 1'b0, 1'b1);
    repeat (30) @(negedge clk);
    rc(asp_pkg::ADDR_DATA, 8'h96, "ext_clk_rx");
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    rc(asp_pkg::ADDR_CTRL, asp_pkg::CTRL_RESET, "ctrl_rerst");
    end_sim();
  end
endmodule

// ==== src/asp_buf2.sv ====
`timescale 1ns/1ps
module asp_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr;
    logic [PW-1:0]           rd;
    logic [CW-1:0]           cnt;
  } asp_buf_st_t;

  asp_buf_st_t st_q;
  asp_buf_st_t st_d;
  logic        push;
  logic        pop;

  assign in_ready  = (st_q.cnt != CNT_FULL);
  assign out_valid = (st_q.cnt != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = st_q.mem[st_q.rd];

  // ==========================================================
  // Storage and pointers
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr = (st_q.wr == PTR_LAST) ? '0 : st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = (st_q.rd == PTR_LAST) ? '0 : st_q.rd + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ==== src/asp_sync.sv ====
`timescale 1ns/1ps
module asp_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } asp_sync_st_t;

  asp_sync_st_t st_q;
  asp_sync_st_t st_d;

  // ==========================================================
  // Three stages; a change counts only when stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL, lvl: RESET_LEVEL};
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;

endmodule

// ==== src/asp_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Bit rate is half the timer overflow rate
// - Start edge forces receive timer reload
// - Data writes transmit, reads return receive latch
// - Timer may tick from external oscillator
// - Control bit 7 selects 8 or 9 bits
// - 8-bit frame: start, eight LSB-first, stop
// - 8-bit: stop bit lands in ninth-bit field
// - Data buffer write starts a transmission
// - Transmit flag sets at stop bit start
// - Receive only while receive enable is set
// - 8-bit accept: flag clear, stop checked if enabled
// - Rejected byte changes no buffer, field, flag
// - Overrun keeps first byte, drops later one
// - 9-bit frame sends ninth bit from field
// - 9-bit: ninth bit stored, stop ignored
// - 9-bit filter accepts only ninth bit one
// - Control bit 5 is the filter enable
// - Interrupt request on either flag, when enabled
// - Receive flag sets at stop bit sample
// - Flags cleared only by software writes
// - Control bit 6 reads one, ignores writes
module asp_top #(
  parameter int TX_DEPTH = 2
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            tx_buf_ready,
  input  wire logic       timer_run,
  input  wire logic       timer_src_ext,
  input  wire logic       ext_osc_clk,
  input  wire logic [7:0] bitrate_reload_value,
  input  wire logic       irq_enable,
  output logic            serial_irq,
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin
);

  typedef struct packed {
    logic                   frame_format_select;
    logic                   multiproc_filter_enable;
    logic                   receiver_enable_bit;
    logic                   tx_ninth_bit;
    logic                   rx_ninth_bit;
    logic                   tx_done_flag;
    logic                   rx_done_flag;
    logic [7:0]             rx_latch;
    logic [7:0]             rdata;
    logic                   ext_prev;
    logic [7:0]             tx_tmr;
    logic                   tx_div;
    logic [7:0]             rx_tmr;
    logic                   rx_div;
    asp_pkg::asp_tx_state_t tx_state;
    logic [7:0]             tx_shift;
    logic [2:0]             tx_cnt;
    logic                   tx_nine;
    logic                   tx_ninth;
    logic                   tx_line;
    asp_pkg::asp_rx_state_t rx_state;
    logic [7:0]             rx_shift;
    logic [2:0]             rx_cnt;
    logic                   rx_nine;
    logic                   rx_ninth;
    logic                   rx_prev;
  } asp_top_st_t;

  asp_top_st_t st_q;
  asp_top_st_t st_d;

  logic       rx_level;
  logic       ext_level;
  logic       tmr_tick;
  logic       tx_ovf;
  logic       rx_ovf;
  logic       tx_baud;
  logic       rx_sample;
  logic       start_edge;
  logic       wr_ctrl;
  logic       wr_data;
  logic [7:0] ctrl_view;
  logic       q_valid;
  logic [7:0] q_data;
  logic       q_pop;
  logic       tx_set;
  logic       rx_set;
  logic       rx_stop_ok;
  logic       rx_nine_val;

  // ==========================================================
  // Pin and oscillator synchronisers
  asp_sync #(
    .RESET_LEVEL (1'b1)
  ) u_rx_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in (serial_in_pin),
    .level    (rx_level)
  );

  asp_sync #(
    .RESET_LEVEL (1'b0)
  ) u_osc_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in (ext_osc_clk),
    .level    (ext_level)
  );

  // ==========================================================
  // Transmit holding buffer; a full buffer drops the write, so software
  // must watch tx_buf_ready before it writes a burst
  assign wr_ctrl = sfr_wr && (sfr_addr == asp_pkg::ADDR_CTRL);
  assign wr_data = sfr_wr && (sfr_addr == asp_pkg::ADDR_DATA);
  assign q_pop   = q_valid && (st_q.tx_state == asp_pkg::ASP_TX_IDLE);

  asp_buf2 #(
    .W     (8),
    .DEPTH (TX_DEPTH)
  ) u_tx_buf (
    .clk       (clk),
    .srst      (srst),
    .in_data   (sfr_wdata),
    .in_valid  (wr_data),
    .in_ready  (tx_buf_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_pop)
  );

  // ==========================================================
  // Bit-rate timers
  // External oscillator edges are counted only after synchronising, so the
  // oscillator must run well below the system clock.
  assign tmr_tick = timer_run && (timer_src_ext ? (ext_level && !st_q.ext_prev) : 1'b1);
  assign tx_ovf   = tmr_tick && (st_q.tx_tmr == asp_pkg::TMR_TOP);
  assign rx_ovf   = tmr_tick && (st_q.rx_tmr == asp_pkg::TMR_TOP);
  assign tx_baud  = tx_ovf && st_q.tx_div;
  // Reload at the start edge puts the first overflow half a bit later, so odd overflows hit cell centres
  assign rx_sample = rx_ovf && !st_q.rx_div;
  assign start_edge = (st_q.rx_state == asp_pkg::ASP_RX_IDLE) && st_q.receiver_enable_bit
                      && st_q.rx_prev && !rx_level;

  // ==========================================================
  // Receive acceptance
  assign rx_nine_val = st_q.rx_nine ? st_q.rx_ninth : rx_level;
  assign rx_stop_ok  = !st_q.rx_done_flag
                       && (!st_q.multiproc_filter_enable || rx_nine_val);
  assign rx_set      = rx_sample && (st_q.rx_state == asp_pkg::ASP_RX_STOP) && rx_stop_ok;
  assign tx_set      = tx_baud && ((st_q.tx_state == asp_pkg::ASP_TX_NINTH) ||
                       (st_q.tx_state == asp_pkg::ASP_TX_DATA && st_q.tx_cnt == asp_pkg::DATA_LAST
                        && !st_q.tx_nine));

  assign ctrl_view = {st_q.frame_format_select, 1'b1, st_q.multiproc_filter_enable,
                      st_q.receiver_enable_bit, st_q.tx_ninth_bit, st_q.rx_ninth_bit,
                      st_q.tx_done_flag, st_q.rx_done_flag};

  // ==========================================================
  // Next state
  always_comb begin
    st_d          = st_q;
    st_d.ext_prev = ext_level;
    st_d.rx_prev  = rx_level;

    if (sfr_rd) begin
      if (sfr_addr == asp_pkg::ADDR_CTRL) begin
        st_d.rdata = ctrl_view;
      end else if (sfr_addr == asp_pkg::ADDR_DATA) begin
        st_d.rdata = st_q.rx_latch;
      end else begin
        st_d.rdata = '0;
      end
    end

    if (wr_ctrl) begin
      st_d.frame_format_select     = sfr_wdata[asp_pkg::CTRL_FMT_BIT];
      st_d.multiproc_filter_enable = sfr_wdata[asp_pkg::CTRL_MCE_BIT];
      st_d.receiver_enable_bit     = sfr_wdata[asp_pkg::CTRL_REN_BIT];
      st_d.tx_ninth_bit            = sfr_wdata[asp_pkg::CTRL_TB8_BIT];
      st_d.rx_ninth_bit            = sfr_wdata[asp_pkg::CTRL_RB8_BIT];
    end
    // A hardware set in the same cycle as a software clear wins
    st_d.tx_done_flag = tx_set || (wr_ctrl ? sfr_wdata[asp_pkg::CTRL_TI_BIT]
                                           : st_q.tx_done_flag);
    st_d.rx_done_flag = rx_set || (wr_ctrl ? sfr_wdata[asp_pkg::CTRL_RI_BIT]
                                           : st_q.rx_done_flag);

    // Timers share the reload value; the receive copy restarts on a start edge
    if (tmr_tick) begin
      st_d.tx_tmr = tx_ovf ? bitrate_reload_value : st_q.tx_tmr + 8'h01;
      st_d.rx_tmr = rx_ovf ? bitrate_reload_value : st_q.rx_tmr + 8'h01;
    end
    if (tx_ovf) begin
      st_d.tx_div = !st_q.tx_div;
    end
    if (rx_ovf) begin
      st_d.rx_div = !st_q.rx_div;
    end
    if (start_edge) begin
      st_d.rx_tmr = bitrate_reload_value;
      st_d.rx_div = 1'b0;
    end

    // Transmitter
    unique case (st_q.tx_state)
      asp_pkg::ASP_TX_IDLE: begin
        st_d.tx_line = 1'b1;
        if (q_valid) begin
          st_d.tx_shift = q_data;
          st_d.tx_nine  = st_q.frame_format_select;
          st_d.tx_ninth = st_q.tx_ninth_bit;
          st_d.tx_state = asp_pkg::ASP_TX_WAIT;
        end
      end
      asp_pkg::ASP_TX_WAIT: begin
        if (tx_baud) begin
          st_d.tx_line  = 1'b0;
          st_d.tx_state = asp_pkg::ASP_TX_START;
        end
      end
      asp_pkg::ASP_TX_START: begin
        if (tx_baud) begin
          st_d.tx_line  = st_q.tx_shift[0];
          st_d.tx_shift = {1'b0, st_q.tx_shift[7:1]};
          st_d.tx_cnt   = '0;
          st_d.tx_state = asp_pkg::ASP_TX_DATA;
        end
      end
      asp_pkg::ASP_TX_DATA: begin
        if (tx_baud) begin
          if (st_q.tx_cnt != asp_pkg::DATA_LAST) begin
            st_d.tx_line  = st_q.tx_shift[0];
            st_d.tx_shift = {1'b0, st_q.tx_shift[7:1]};
            st_d.tx_cnt   = st_q.tx_cnt + 3'h1;
          end else if (st_q.tx_nine) begin
            st_d.tx_line  = st_q.tx_ninth;
            st_d.tx_state = asp_pkg::ASP_TX_NINTH;
          end else begin
            st_d.tx_line  = 1'b1;
            st_d.tx_state = asp_pkg::ASP_TX_STOP;
          end
        end
      end
      asp_pkg::ASP_TX_NINTH: begin
        if (tx_baud) begin
          st_d.tx_line  = 1'b1;
          st_d.tx_state = asp_pkg::ASP_TX_STOP;
        end
      end
      asp_pkg::ASP_TX_STOP: begin
        if (tx_baud) begin
          st_d.tx_state = asp_pkg::ASP_TX_IDLE;
        end
      end
    endcase

    // Receiver; clearing the enable mid-frame abandons the frame
    unique case (st_q.rx_state)
      asp_pkg::ASP_RX_IDLE: begin
        if (start_edge) begin
          st_d.rx_nine  = st_q.frame_format_select;
          st_d.rx_state = asp_pkg::ASP_RX_START;
        end
      end
      asp_pkg::ASP_RX_START: begin
        if (rx_sample) begin
          // A high line at mid start cell is a glitch, not a start bit
          st_d.rx_state = rx_level ? asp_pkg::ASP_RX_IDLE : asp_pkg::ASP_RX_DATA;
          st_d.rx_cnt   = '0;
        end
      end
      asp_pkg::ASP_RX_DATA: begin
        if (rx_sample) begin
          st_d.rx_shift = {rx_level, st_q.rx_shift[7:1]};
          st_d.rx_cnt   = st_q.rx_cnt + 3'h1;
          if (st_q.rx_cnt == asp_pkg::DATA_LAST) begin
            st_d.rx_state = st_q.rx_nine ? asp_pkg::ASP_RX_NINTH : asp_pkg::ASP_RX_STOP;
          end
        end
      end
      asp_pkg::ASP_RX_NINTH: begin
        if (rx_sample) begin
          st_d.rx_ninth = rx_level;
          st_d.rx_state = asp_pkg::ASP_RX_STOP;
        end
      end
      asp_pkg::ASP_RX_STOP: begin
        if (rx_sample) begin
          st_d.rx_state = asp_pkg::ASP_RX_IDLE;
          // Unaccepted bytes, including overruns, never touch the latch
          if (rx_stop_ok) begin
            st_d.rx_latch     = st_q.rx_shift;
            st_d.rx_ninth_bit = rx_nine_val;
          end
        end
      end
    endcase
    if (!st_q.receiver_enable_bit) begin
      st_d.rx_state = asp_pkg::ASP_RX_IDLE;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q          <= '0;
      st_q.tx_line  <= 1'b1;
      st_q.rx_prev  <= 1'b1;
      st_q.rx_latch <= asp_pkg::DATA_RESET;
      st_q.tx_state <= asp_pkg::ASP_TX_IDLE;
      st_q.rx_state <= asp_pkg::ASP_RX_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata      = st_q.rdata;
  assign serial_out_pin = st_q.tx_line;
  assign serial_irq     = irq_enable && (st_q.tx_done_flag || st_q.rx_done_flag);

endmodule
